// file: rtl/sap_cfg.svh
// sap_cfg.svh: register offsets, field positions, reset values and counts of the serial audio ports
`ifndef SAP_CFG_SVH
`define SAP_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SAP_ADDR_IN_CTL 4'h0
`define SAP_ADDR_OUT_CTL 4'h4
`define SAP_ADDR_STATUS 4'h8

// ****************************************
// control fields
// ****************************************
`define SAP_FMT_HI 2
`define SAP_FMT_LO 0
`define SAP_BINV_BIT 3
`define SAP_LINV_BIT 4
`define SAP_RJ_HI 6
`define SAP_RJ_LO 5
`define SAP_MST_BIT 7
`define SAP_DIV_HI 11
`define SAP_DIV_LO 8

// ****************************************
// reset values
// ****************************************
`define SAP_IN_CTL_RST 7'h00
`define SAP_OUT_CTL_RST 12'h300
`define SAP_GEN_POS_RST 8'hFF

// ****************************************
// bit counts
// ****************************************
`define SAP_WORD_MAX 5'h18
`define SAP_MSB_IDX 5'h17
`define SAP_SLOT_BITS 6'h20
`define SAP_ONE_DELAY 5'h01
`define SAP_LJ_DELAY 5'h00
`define SAP_RJ_D8 5'h08
`define SAP_RJ_D12 5'h0C
`define SAP_RJ_D16 5'h10
`define SAP_LAST_2CH 8'h3F
`define SAP_LAST_TDM 8'hFF
`define SAP_HALF_2CH 8'h20
`define SAP_HALF_TDM 8'h80
`define SAP_POS_MAX 8'hFF

`endif

// file: rtl/sap_lane_if.sv
// sap_lane_if.sv: bit timing strobes from a port engine to its data lanes
`timescale 1ns/1ps
interface sap_lane_if;
   logic tick;
   logic clr;
   logic en;
   logic [4:0] idx;
   modport ctl (output tick, output clr, output en, output idx);
   modport lane (input tick, input clr, input en, input idx);
endinterface : sap_lane_if

// file: rtl/sap_pkg.sv
// sap_pkg.sv: shared types of the serial audio ports
package sap_pkg;
   typedef enum logic [2:0] {
      SAP_FMT_I2S,
      SAP_FMT_LJ,
      SAP_FMT_RJ,
      SAP_FMT_TDM_CLK,
      SAP_FMT_TDM_PULSE
   } sap_fmt_e;
   typedef logic [23:0] sap_word_t;
endpackage : sap_pkg

// file: rtl/sap_rx_lane.sv
// sap_rx_lane.sv: deserialiser for one input data lane
`timescale 1ns/1ps
`include "sap_cfg.svh"
module sap_rx_lane (
   input wire logic clk,
   input wire logic rst_n,
   sap_lane_if.lane ctl,
   input wire logic bit_i,
   output sap_pkg::sap_word_t word_q
);
   sap_pkg::sap_word_t word_d;

   // bits land msb first, so a short word ends up left aligned
   always_comb begin
      word_d = ctl.clr ? '0 : word_q;
      if (ctl.en) begin
         word_d[`SAP_MSB_IDX - ctl.idx] = bit_i;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= '0;
      end else if (ctl.tick) begin
         word_q <= word_d;
      end
   end
endmodule : sap_rx_lane

// file: rtl/sap_top.sv
// sap_top.sv: serial audio input and output ports with their control registers
// Summary of operation
// - accept up to 24 bits, drop extras
// - right justified: msb after 8/12/16, lsb at edge
// - reset selects two-channel i2s on both ports
// - settings act alike, master or slave
// - output sets polarities, rate, frame type, format
// - input has four lanes, frame and bit clock
// - output drives four lanes with own clocks
// - input and output settings held apart
// - input always slave; output master or slave
// - master output clocks may loop to input
// - external dac served by output port only
// - data changes on falling bit clock
// - i2s: falling frame edge, msb one later
// - left justified: rising edge, msb aligned
// - tdm clock: falling edge, msb one later
// - tdm pulse: one-bit pulse, msb one later
// - tdm channels all on lane zero
// - slots 0-3 first half, 4-7 second
// - twos complement, msb first, left first
`timescale 1ns/1ps
`include "sap_cfg.svh"
module sap_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   input wire logic in_bclk,
   input wire logic in_lrclk,
   input wire logic [3:0] input_data_lane,
   input wire logic out_bclk_i,
   output logic out_bclk_o_q,
   output logic out_bclk_oe_n_q,
   input wire logic out_lrclk_i,
   output logic out_lrclk_o_q,
   output logic out_lrclk_oe_n_q,
   output logic [3:0] output_data_lane_q,
   output logic rx_valid_q,
   output logic [2:0] rx_slot_q,
   output logic [95:0] rx_data_q,
   input wire logic tx_wr,
   input wire logic [2:0] tx_chan,
   input wire logic [23:0] tx_word
);
   // ****************************************
   // format helpers
   // ****************************************
   function automatic logic f_tdm(input sap_pkg::sap_fmt_e f);
      f_tdm = (f == sap_pkg::SAP_FMT_TDM_CLK) || (f == sap_pkg::SAP_FMT_TDM_PULSE);
   endfunction : f_tdm

   // frame clock level after the frame start edge; in two-channel it marks left
   function automatic logic f_start_lvl(input sap_pkg::sap_fmt_e f);
      f_start_lvl = (f == sap_pkg::SAP_FMT_LJ) || (f == sap_pkg::SAP_FMT_RJ) ||
         (f == sap_pkg::SAP_FMT_TDM_PULSE);
   endfunction : f_start_lvl

   function automatic logic [4:0] f_msb(input sap_pkg::sap_fmt_e f, input logic [1:0] rj);
      case (f)
         sap_pkg::SAP_FMT_LJ: f_msb = `SAP_LJ_DELAY;
         sap_pkg::SAP_FMT_RJ: f_msb = (rj == 2'h0) ? `SAP_RJ_D8 :
            ((rj == 2'h1) ? `SAP_RJ_D12 : `SAP_RJ_D16);
         default: f_msb = `SAP_ONE_DELAY;
      endcase
   endfunction : f_msb

   // right justified words end on the frame clock edge
   function automatic logic [4:0] f_len(input sap_pkg::sap_fmt_e f, input logic [4:0] msb);
      f_len = (f == sap_pkg::SAP_FMT_RJ) ? 5'(`SAP_SLOT_BITS - {1'b0, msb}) :
         `SAP_WORD_MAX;
   endfunction : f_len

   // ****************************************
   // control registers
   // ****************************************
   logic [6:0] in_ctl_q;
   logic [11:0] out_ctl_q;
   logic [7:0] rx_frames_q;
   logic [7:0] tx_frames_q;

   // two separate registers so each port is set on its own
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_ctl_q <= `SAP_IN_CTL_RST;
         out_ctl_q <= `SAP_OUT_CTL_RST;
      end else if (reg_wr) begin
         if (reg_addr == `SAP_ADDR_IN_CTL) begin
            in_ctl_q <= reg_wdata[6:0];
         end
         if (reg_addr == `SAP_ADDR_OUT_CTL) begin
            out_ctl_q <= reg_wdata[11:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `SAP_ADDR_IN_CTL: reg_rdata_q <= {25'h0000000, in_ctl_q};
            `SAP_ADDR_OUT_CTL: reg_rdata_q <= {20'h00000, out_ctl_q};
            `SAP_ADDR_STATUS: reg_rdata_q <= {16'h0000, tx_frames_q, rx_frames_q};
            default: reg_rdata_q <= '0;
         endcase
      end else begin
         reg_rdata_q <= '0;
      end
   end

   sap_pkg::sap_fmt_e in_fmt;
   sap_pkg::sap_fmt_e out_fmt;
   logic out_master;
   assign in_fmt = sap_pkg::sap_fmt_e'(in_ctl_q[`SAP_FMT_HI:`SAP_FMT_LO]);
   assign out_fmt = sap_pkg::sap_fmt_e'(out_ctl_q[`SAP_FMT_HI:`SAP_FMT_LO]);
   assign out_master = out_ctl_q[`SAP_MST_BIT];

   // ****************************************
   // input port: always slave
   // ****************************************
   logic [5:0] rx_s1_q;
   logic [5:0] rx_s2_q;
   logic rx_bclk, rx_lr, rx_tdm, rx_tick, rx_edge, rx_fs, rx_restart, rx_start, rx_en;
   logic rx_bclk_q, rx_lr_q, rx_seen_q;
   logic [7:0] rx_pos_q, rx_pos_d, rx_off;
   logic [4:0] rx_n_q, rx_n_eff, rx_msb, rx_len;
   logic [2:0] rx_cur_q, rx_slot_d;
   sap_pkg::sap_word_t rx_word [4];
   sap_lane_if rx_if ();

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_q <= '0;
         rx_s2_q <= '0;
      end else begin
         rx_s1_q <= {in_lrclk, in_bclk, input_data_lane};
         rx_s2_q <= rx_s1_q;
      end
   end

   assign rx_bclk = rx_s2_q[4] ^ in_ctl_q[`SAP_BINV_BIT];
   assign rx_lr = rx_s2_q[5] ^ in_ctl_q[`SAP_LINV_BIT];
   assign rx_tdm = f_tdm(in_fmt);
   assign rx_msb = f_msb(in_fmt, in_ctl_q[`SAP_RJ_HI:`SAP_RJ_LO]);
   assign rx_len = f_len(in_fmt, rx_msb);
   // sample on the rising bit clock, since the sender changes on the falling one
   assign rx_tick = rx_bclk & ~rx_bclk_q;
   assign rx_edge = rx_tick & (rx_lr != rx_lr_q);
   assign rx_fs = rx_edge & (rx_lr == f_start_lvl(in_fmt));
   assign rx_restart = rx_fs | (rx_edge & ~rx_tdm);
   assign rx_pos_d = rx_restart ? 8'h00 :
      ((rx_pos_q == `SAP_POS_MAX) ? rx_pos_q : rx_pos_q + 8'h01);
   assign rx_off = rx_tdm ? {3'h0, rx_pos_d[4:0]} : rx_pos_d;
   assign rx_start = rx_restart | (rx_tdm & (rx_pos_d[4:0] == 5'h00));
   assign rx_n_eff = rx_start ? 5'h00 : rx_n_q;
   assign rx_en = (rx_off >= {3'h0, rx_msb}) && (rx_n_eff < rx_len);
   assign rx_slot_d = rx_tdm ? rx_pos_d[7:5] :
      {2'h0, rx_lr != f_start_lvl(in_fmt)};

   assign rx_if.tick = rx_tick;
   assign rx_if.clr = rx_start;
   assign rx_if.en = rx_en;
   assign rx_if.idx = rx_n_eff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_bclk_q <= 1'b0;
         rx_lr_q <= 1'b0;
         rx_pos_q <= 8'h00;
         rx_n_q <= 5'h00;
         rx_cur_q <= 3'h0;
         rx_seen_q <= 1'b0;
      end else begin
         rx_bclk_q <= rx_bclk;
         if (rx_tick) begin
            rx_lr_q <= rx_lr;
            rx_pos_q <= rx_pos_d;
            rx_n_q <= rx_en ? rx_n_eff + 5'h01 : rx_n_eff;
            if (rx_start) begin
               rx_cur_q <= rx_slot_d;
            end
            if (rx_fs) begin
               rx_seen_q <= 1'b1;
            end
         end
      end
   end

   // a finished word leaves when the next word begins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid_q <= 1'b0;
         rx_slot_q <= 3'h0;
         rx_data_q <= '0;
         rx_frames_q <= 8'h00;
      end else begin
         rx_valid_q <= rx_tick & rx_start & rx_seen_q;
         if (rx_tick && rx_start) begin
            rx_slot_q <= rx_cur_q;
            rx_data_q <= {rx_word[3], rx_word[2], rx_word[1], rx_word[0]};
         end
         if (rx_fs) begin
            rx_frames_q <= rx_frames_q + 8'h01;
         end
      end
   end

   // ****************************************
   // output port clock generator
   // ****************************************
   logic [3:0] gen_div_q;
   logic gen_bclk_q, gen_lr_q;
   logic [7:0] gen_pos_q, gen_next, gen_last, gen_half;
   logic tx_tdm;

   assign tx_tdm = f_tdm(out_fmt);
   assign gen_last = tx_tdm ? `SAP_LAST_TDM : `SAP_LAST_2CH;
   assign gen_half = tx_tdm ? `SAP_HALF_TDM : `SAP_HALF_2CH;
   assign gen_next = (gen_pos_q >= gen_last) ? 8'h00 : gen_pos_q + 8'h01;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gen_div_q <= 4'h0;
         gen_bclk_q <= 1'b1;
         gen_lr_q <= 1'b1;
         gen_pos_q <= `SAP_GEN_POS_RST;
      end else if (!out_master) begin
         gen_div_q <= 4'h0;
         gen_bclk_q <= 1'b1;
      end else if (gen_div_q == out_ctl_q[`SAP_DIV_HI:`SAP_DIV_LO]) begin
         gen_div_q <= 4'h0;
         gen_bclk_q <= ~gen_bclk_q;
         if (gen_bclk_q) begin
            gen_pos_q <= gen_next;
            gen_lr_q <= (out_fmt == sap_pkg::SAP_FMT_TDM_PULSE) ? (gen_next == 8'h00) :
               (f_start_lvl(out_fmt) ^ (gen_next >= gen_half));
         end
      end else begin
         gen_div_q <= gen_div_q + 4'h1;
      end
   end

   // master clocks drive the pins, ready to loop back to the input port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_bclk_o_q <= 1'b0;
         out_lrclk_o_q <= 1'b0;
         out_bclk_oe_n_q <= 1'b1;
         out_lrclk_oe_n_q <= 1'b1;
      end else begin
         out_bclk_o_q <= gen_bclk_q ^ out_ctl_q[`SAP_BINV_BIT];
         out_lrclk_o_q <= gen_lr_q ^ out_ctl_q[`SAP_LINV_BIT];
         out_bclk_oe_n_q <= ~out_master;
         out_lrclk_oe_n_q <= ~out_master;
      end
   end

   // ****************************************
   // output port engine, master or slave
   // ****************************************
   logic [1:0] tx_s1_q;
   logic [1:0] tx_s2_q;
   logic tx_bclk, tx_lr, tx_tick, tx_edge, tx_fs, tx_restart, tx_start, tx_en;
   logic tx_bclk_q, tx_lr_q, tx_seen_q;
   logic [7:0] tx_pos_q, tx_pos_d, tx_off;
   logic [4:0] tx_n_q, tx_n_eff, tx_msb, tx_len;
   logic [2:0] tx_slot_d;
   sap_pkg::sap_word_t tx_buf_q [8];
   sap_pkg::sap_word_t tx_lane_word [4];
   sap_lane_if tx_if ();

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_s1_q <= '0;
         tx_s2_q <= '0;
      end else begin
         tx_s1_q <= {out_lrclk_i, out_bclk_i};
         tx_s2_q <= tx_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            tx_buf_q[i] <= '0;
         end
      end else if (tx_wr) begin
         tx_buf_q[tx_chan] <= tx_word;
      end
   end

   // the same timing path serves generated and received clocks
   assign tx_bclk = out_master ? gen_bclk_q : tx_s2_q[0] ^ out_ctl_q[`SAP_BINV_BIT];
   assign tx_lr = out_master ? gen_lr_q : tx_s2_q[1] ^ out_ctl_q[`SAP_LINV_BIT];
   assign tx_msb = f_msb(out_fmt, out_ctl_q[`SAP_RJ_HI:`SAP_RJ_LO]);
   assign tx_len = f_len(out_fmt, tx_msb);
   assign tx_tick = ~tx_bclk & tx_bclk_q;
   assign tx_edge = tx_tick & (tx_lr != tx_lr_q);
   assign tx_fs = tx_edge & (tx_lr == f_start_lvl(out_fmt));
   assign tx_restart = tx_fs | (tx_edge & ~tx_tdm);
   assign tx_pos_d = tx_restart ? 8'h00 :
      ((tx_pos_q == `SAP_POS_MAX) ? tx_pos_q : tx_pos_q + 8'h01);
   assign tx_off = tx_tdm ? {3'h0, tx_pos_d[4:0]} : tx_pos_d;
   assign tx_start = tx_restart | (tx_tdm & (tx_pos_d[4:0] == 5'h00));
   assign tx_n_eff = tx_start ? 5'h00 : tx_n_q;
   assign tx_en = (tx_seen_q | tx_fs) && (tx_off >= {3'h0, tx_msb}) &&
      (tx_n_eff < tx_len);
   assign tx_slot_d = tx_tdm ? tx_pos_d[7:5] :
      {2'h0, tx_lr != f_start_lvl(out_fmt)};

   assign tx_if.tick = tx_tick;
   assign tx_if.clr = tx_start;
   assign tx_if.en = tx_en;
   assign tx_if.idx = tx_n_eff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_bclk_q <= 1'b0;
         tx_lr_q <= 1'b0;
         tx_pos_q <= 8'h00;
         tx_n_q <= 5'h00;
         tx_seen_q <= 1'b0;
         tx_frames_q <= 8'h00;
      end else begin
         tx_bclk_q <= tx_bclk;
         if (tx_tick) begin
            tx_lr_q <= tx_lr;
            tx_pos_q <= tx_pos_d;
            tx_n_q <= tx_en ? tx_n_eff + 5'h01 : tx_n_eff;
         end
         if (tx_fs) begin
            tx_seen_q <= 1'b1;
            tx_frames_q <= tx_frames_q + 8'h01;
         end
      end
   end

   // ****************************************
   // data lanes
   // ****************************************
   for (genvar l = 0; l < 4; l++) begin : g_lane
      assign tx_lane_word[l] = tx_tdm ? ((l == 0) ? tx_buf_q[tx_slot_d] : '0) :
         tx_buf_q[{2'(l), tx_slot_d[0]}];
      sap_rx_lane u_rx (
         .clk(clk),
         .rst_n(rst_n),
         .ctl(rx_if.lane),
         .bit_i(rx_s2_q[l]),
         .word_q(rx_word[l])
      );
      sap_tx_lane u_tx (
         .clk(clk),
         .rst_n(rst_n),
         .ctl(tx_if.lane),
         .word_i(tx_lane_word[l]),
         .bit_q(output_data_lane_q[l])
      );
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_rx_bit_limit: assert property (rx_if.en |-> rx_if.idx < `SAP_WORD_MAX)
      else $error("input word grew past 24 bits");
   a_rj_lsb_edge: assert property (tx_tick && out_fmt == sap_pkg::SAP_FMT_RJ && tx_seen_q &&
      !tx_restart && tx_pos_d == 8'h1F |-> tx_en && tx_n_eff == tx_len - 5'h01)
      else $error("right justified lsb not on the frame edge");
   a_reset_i2s_fmt: assert property (!$past(rst_n) |->
      in_fmt == sap_pkg::SAP_FMT_I2S && out_fmt == sap_pkg::SAP_FMT_I2S)
      else $error("format after reset is not i2s");
   a_master_drive_pins: assert property (1'b1 |=>
      out_bclk_oe_n_q == !$past(out_master) && out_lrclk_oe_n_q == !$past(out_master))
      else $error("clock pin enables disagree with master setting");
   a_tx_change_fall: assert property ($changed(output_data_lane_q) |-> $past(tx_tick))
      else $error("output data changed away from a falling bit clock");
   a_i2s_msb_delay: assert property (rx_tick && in_fmt == sap_pkg::SAP_FMT_I2S &&
      rx_en && rx_n_eff == 5'h00 |-> rx_pos_d == 8'h01)
      else $error("i2s msb not one bit after frame edge");
   a_lj_msb_align: assert property (rx_tick && in_fmt == sap_pkg::SAP_FMT_LJ && rx_restart
      |-> rx_en && rx_n_eff == 5'h00)
      else $error("left justified msb not aligned with frame edge");
   a_tdm_slot_gap: assert property (tx_tick && tx_tdm && tx_start |-> !tx_en)
      else $error("tdm msb not delayed by one bit");
   a_gen_pulse_width: assert property (out_master && out_fmt == sap_pkg::SAP_FMT_TDM_PULSE &&
      gen_lr_q |-> gen_pos_q == 8'h00)
      else $error("generated frame pulse wider than one bit");
   a_tdm_lane_zero: assert property (tx_tick && tx_tdm && tx_seen_q
      |=> output_data_lane_q[3:1] == 3'h0)
      else $error("tdm data outside lane zero");

   c_rx_tdm_slot7: cover property (rx_valid_q && rx_tdm && rx_slot_q == 3'h7);
   c_rx_i2s_right: cover property (rx_valid_q && in_fmt == sap_pkg::SAP_FMT_I2S && rx_slot_q[0]);
   c_tx_master_frame: cover property (out_master && tx_fs);
   c_tx_rj_word: cover property (tx_tick && out_fmt == sap_pkg::SAP_FMT_RJ && tx_restart);
endmodule : sap_top

// file: rtl/sap_tx_lane.sv
// sap_tx_lane.sv: serialiser for one output data lane
`timescale 1ns/1ps
`include "sap_cfg.svh"
module sap_tx_lane (
   input wire logic clk,
   input wire logic rst_n,
   sap_lane_if.lane ctl,
   input sap_pkg::sap_word_t word_i,
   output logic bit_q
);
   sap_pkg::sap_word_t held_q;
   sap_pkg::sap_word_t src;

   assign src = ctl.clr ? word_i : held_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q <= '0;
      end else if (ctl.tick && ctl.clr) begin
         held_q <= word_i;
      end
   end

   // idle bit periods carry zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q <= 1'b0;
      end else if (ctl.tick) begin
         bit_q <= ctl.en ? src[`SAP_MSB_IDX - ctl.idx] : 1'b0;
      end
   end
endmodule : sap_tx_lane

// file: verification/sap_conv_model.sv
// sap_conv_model.sv: external converter that masters the input port clocks and sends frames
`timescale 1ns/1ps
module sap_conv_model (
   input wire logic run,
   input wire logic lj,
   input wire logic [191:0] words,
   output logic bclk,
   output logic lrclk,
   output logic [3:0] lane
);
   int p;
   int b;
   initial begin
      bclk = 1'h0;
      lrclk = 1'h1;
      lane = 4'h0;
      forever begin
         // clocks stand still while run is low; with run high the frames follow back to back
         while (!run) begin
            lrclk = !lj;
            #10;
         end
         for (p = 0; p < 64; p++) begin
            lrclk = lj ? (p < 32) : (p >= 32);
            b = lj ? (p % 32) : (p % 32) - 1;
            for (int l = 0; l < 4; l++) begin
               // msb first, left word first; unused bits show the inverse of the last bit
               lane[l] = (b >= 0 && b < 24) ? words[(2 * l + p / 32) * 24 + 23 - b] : ~lane[l];
            end
            #62.5 bclk = 1'h1;
            #62.5 bclk = 1'h0;
         end
      end
   end
endmodule : sap_conv_model

// file: verification/testbench.sv
// testbench.sv: self-checking bench of the serial audio ports
`timescale 1ns/1ps
`include "sap_cfg.svh"
module testbench;
   typedef struct {
      logic [3:0] wa;
      logic [31:0] wd;
      logic [3:0] ra;
      logic [31:0] rv;
   } sap_row_s;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic tx_wr = 1'h0;
   logic [2:0] tx_chan = 3'h0;
   logic [23:0] tx_word = 24'h0;
   logic m_run = 1'h0;
   logic m_lj = 1'h0;
   logic [191:0] m_words;
   logic m_bclk, m_lrclk;
   logic [3:0] m_lane;
   logic [31:0] reg_rdata_q;
   logic out_bclk_o_q, out_bclk_oe_n_q, out_lrclk_o_q, out_lrclk_oe_n_q, rx_valid_q;
   logic [3:0] output_data_lane_q;
   logic [2:0] rx_slot_q;
   logic [95:0] rx_data_q;
   sap_row_s rows [7];
   int bad_count = 0;
   int checked = 0;
   always #5 clk = ~clk;
   sap_conv_model conv_u (.run(m_run), .lj(m_lj), .words(m_words), .bclk(m_bclk),
      .lrclk(m_lrclk), .lane(m_lane));
   sap_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .in_bclk(m_bclk),
      .in_lrclk(m_lrclk), .input_data_lane(m_lane), .out_bclk_i(m_bclk),
      .out_bclk_o_q(out_bclk_o_q), .out_bclk_oe_n_q(out_bclk_oe_n_q), .out_lrclk_i(m_lrclk),
      .out_lrclk_o_q(out_lrclk_o_q), .out_lrclk_oe_n_q(out_lrclk_oe_n_q),
      .output_data_lane_q(output_data_lane_q), .rx_valid_q(rx_valid_q), .rx_slot_q(rx_slot_q),
      .rx_data_q(rx_data_q), .tx_wr(tx_wr), .tx_chan(tx_chan), .tx_word(tx_word));
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task automatic fail_out;
      bad_count++;
      results();
   endtask : fail_out
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata_q;
   endtask : rd
   task automatic txw(input logic [2:0] c, input logic [23:0] w);
      @(posedge clk);
      tx_chan <= c;
      tx_word <= w;
      tx_wr <= 1'h1;
      @(posedge clk);
      tx_wr <= 1'h0;
   endtask : txw
   // waits for the word set of one channel and compares all four lanes
   task automatic rx_word(input logic [2:0] s);
      int n;
      logic [95:0] exp;
      for (int l = 0; l < 4; l++) exp[l * 24 +: 24] = m_words[(2 * l + s) * 24 +: 24];
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (!(rx_valid_q === 1'h1 && rx_slot_q === s) && n < 4000);
      if (n >= 4000) fail_out();
      check(rx_data_q, exp);
   endtask : rx_word
   // skips frame starts, then takes 25 lane zero bits at bit clock rises
   task automatic cap_frame(input logic sl, input int skip, output logic [24:0] cap,
      output int dt);
      int n;
      int t0;
      logic lb;
      logic bb;
      logic lr;
      logic bc;
      cap = 25'h0;
      n = 0;
      t0 = 0;
      dt = 0;
      lb = 1'h0;
      bb = 1'h1;
      for (int t = 0; n < 25 && t < 4000; t++) begin
         @(posedge clk);
         #1 lr = sl ? m_lrclk : out_lrclk_o_q;
         bc = sl ? m_bclk : out_bclk_o_q;
         if (skip > 0) begin
            if (lb === 1'h1 && lr === 1'h0) skip--;
         end else if (bb === 1'h0 && bc === 1'h1) begin
            cap = {cap[23:0], output_data_lane_q[0]};
            n++;
            if (n == 1) t0 = t;
            dt = t - t0;
         end
         lb = lr;
         bb = bc;
      end
      if (n < 25) fail_out();
   endtask : cap_frame
   initial begin
      int dt;
      logic [31:0] d;
      logic [24:0] cap;
      for (int k = 0; k < 8; k++) m_words[k * 24 +: 24] = 24'hC35A81 ^ 24'(k * 24'h111111);
      rows = '{'{`SAP_ADDR_STATUS, 32'hFFFFFFFF, `SAP_ADDR_STATUS, 32'h00000000},
         '{`SAP_ADDR_IN_CTL, 32'hFFFFFFFF, `SAP_ADDR_IN_CTL, 32'h0000007F},
         '{`SAP_ADDR_OUT_CTL, 32'h00000000, `SAP_ADDR_IN_CTL, 32'h0000007F},
         '{`SAP_ADDR_OUT_CTL, 32'hFFFFFFFF, `SAP_ADDR_OUT_CTL, 32'h00000FFF},
         '{4'hC, 32'hFFFFFFFF, 4'hC, 32'h00000000},
         '{`SAP_ADDR_IN_CTL, 32'h00000000, `SAP_ADDR_OUT_CTL, 32'h00000FFF},
         '{`SAP_ADDR_OUT_CTL, 32'h00000000, `SAP_ADDR_OUT_CTL, 32'h00000000}};
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      #1 check(out_bclk_oe_n_q, 1'h1);
      check(out_lrclk_oe_n_q, 1'h1);
      rd(`SAP_ADDR_IN_CTL, d);
      check(d, 32'h0);
      rd(`SAP_ADDR_OUT_CTL, d);
      check(d, 32'h300);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, d);
         check(d, rows[i].rv);
      end
      $display("test registers done");
      // ******
      // input port: i2s, then left justified
      // ******
      for (int f = 0; f < 2; f++) begin
         wr(`SAP_ADDR_IN_CTL, 32'(f));
         m_lj <= f[0];
         m_run <= 1'h1;
         rx_word(3'h0);
         rx_word(3'h1);
         m_run <= 1'h0;
         repeat (1000) @(posedge clk);
         $display("test receive format %0d done", f);
      end
      // ******
      // output port as master, i2s, divider 3
      // ******
      txw(3'h0, 24'hA5C3F1);
      txw(3'h1, 24'h5A3C0E);
      wr(`SAP_ADDR_OUT_CTL, 32'h00000380);
      repeat (4) @(posedge clk);
      #1 check(out_bclk_oe_n_q, 1'h0);
      check(out_lrclk_oe_n_q, 1'h0);
      cap_frame(1'h0, 1, cap, dt);
      check(dt, 192);
      check(cap, {1'h0, 24'hA5C3F1});
      $display("test transmit master done");
      // ******
      // output port as slave, clocks from the converter model
      // ******
      wr(`SAP_ADDR_OUT_CTL, 32'h00000000);
      m_lj <= 1'h0;
      m_run <= 1'h1;
      cap_frame(1'h1, 2, cap, dt);
      m_run <= 1'h0;
      check(out_bclk_oe_n_q, 1'h1);
      check(dt, 300);
      check(cap, {1'h0, 24'hA5C3F1});
      $display("test transmit slave done");
      results();
   end
endmodule : testbench
